// *** tb/tb.sv ***
`timescale 1ns/1ps
`include "rxc_defs.svh"

`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_errors++; \
  $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end

module tb;
  // ------------------------------------------------------------
  // Design signals
  // ------------------------------------------------------------
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr, low_band_input, high_band_input_one, high_band_input_two;
  logic        lna_reduce, mix_reduce, sdm_osr_4x, vcm_high, swap_q, swap_i;
  logic        filt_reserved, chip_reset_active;
  logic [15:0] synth_freq_word, synth_lo_div_word;
  logic [6:0]  rx_gain;
  logic [4:0]  gain_cal;
  logic [8:0]  eff_gain;
  logic [1:0]  filt_mode;
  logic [3:0]  skip_mask, sdm_enable, mix_thresh, lna_thresh, offset_adc_range;
  logic [3:0]  state2_duration, state1_duration, state0_duration;
  logic [3:0]  state3_integrator, state2_integrator, state1_integrator, state0_integrator;
  int          n_errors = 0, checks = 0;
  int          srst_cnt = 0;
  localparam int unsigned SRST_SIM = 16;

  // Short pulse keeps the run brief
  rxc_regs #(.SRST_CYC(SRST_SIM)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .prdata, .pslverr, .synth_freq_word, .synth_lo_div_word,
    .low_band_input, .high_band_input_one, .high_band_input_two, .rx_gain, .gain_cal,
    .eff_gain, .lna_reduce, .mix_reduce, .skip_mask, .sdm_enable, .mix_thresh, .lna_thresh,
    .offset_adc_range, .state2_duration, .state1_duration, .state0_duration,
    .state3_integrator, .state2_integrator, .state1_integrator, .state0_integrator,
    .sdm_osr_4x, .vcm_high, .swap_q, .swap_i, .filt_mode, .filt_reserved,
    .chip_reset_active);

  always #2.5 pclk = ~pclk;

  // Edges that see the soft reset flag high
  always @(posedge pclk)
    if (chip_reset_active === 1'b1)
      srst_cnt <= srst_cnt + 1;

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  task automatic apb(input logic [7:0] idx, input logic wr, input logic [31:0] wd,
                     input logic ex_err, input logic [31:0] ex_rd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= 12'({idx, 2'b00});
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
    begin
      n_errors++;
      tally_and_finish;
    end
    `CHK("pslverr", ex_err, pslverr)
    if (!wr)
      `CHK("prdata", ex_rd, prdata)
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask : settle

  task automatic chk_defaults;
    `CHK("thr", 16'h0FA6, {skip_mask, sdm_enable, mix_thresh, lna_thresh})
    `CHK("dur", 16'h103E, {offset_adc_range, state2_duration, state1_duration,
                           state0_duration})
    `CHK("int", 16'hEE53, {state3_integrator, state2_integrator, state1_integrator,
                           state0_integrator})
    `CHK("bb", 12'h010, {vcm_high, swap_q, swap_i, filt_reserved, filt_mode, gain_cal,
                         sdm_osr_4x})
    `CHK("band", 3'b010, {high_band_input_two, high_band_input_one, low_band_input})
    `CHK("freq", 16'h0000, synth_freq_word)
    `CHK("cal", 5'd8, gain_cal)
  endtask : chk_defaults

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin : main
    int c, n;
    logic [8:0] g9;
    logic [6:0] gl [4];
    gl = '{7'd11, 7'd12, 7'd47, 7'd48};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    settle;
    chk_defaults;
    // Frequency word, low band word is half
    apb(`RXC_IDX_FREQ, 1, 32'h0000_9470, 0, 0); settle;
    `CHK("lo", 16'h4A38, synth_lo_div_word)
    apb(`RXC_IDX_FREQ, 1, 32'hFFFF_9858, 0, 0); settle;
    `CHK("freq", 16'h9858, synth_freq_word)
    `CHK("lo", 16'h4C2C, synth_lo_div_word)
    // Write-only: read refused, unmapped write not stored
    apb(`RXC_IDX_FREQ, 0, 0, 1, 0);
    apb(8'h20, 1, 32'h0000_1111, 1, 0);
    // Partial strobe refused, nothing stored
    pstrb <= 4'hE;
    apb(`RXC_IDX_FREQ, 1, 32'h0000_2222, 1, 0);
    pstrb <= 4'hF;
    settle;
    `CHK("freq", 16'h9858, synth_freq_word)
    // Thresholds, durations, integrators
    apb(`RXC_IDX_THRESH, 1, 32'hFFFF_5A3C, 0, 0);
    apb(`RXC_IDX_DUR, 1, 32'h0000_9C27, 0, 0);
    apb(`RXC_IDX_INTEG, 1, 32'h0000_1B6D, 0, 0); settle;
    `CHK("thr", 16'h5A3C, {skip_mask, sdm_enable, mix_thresh, lna_thresh})
    `CHK("dur", 16'h9C27, {offset_adc_range, state2_duration, state1_duration,
                           state0_duration})
    `CHK("int", 16'h1B6D, {state3_integrator, state2_integrator, state1_integrator,
                           state0_integrator})
    // Decoder thresholds at 4 dB steps: mixer 12 dB, LNA 48 dB
    for (c = 0; c < 4; c++)
    begin
      apb(`RXC_IDX_GAIN, 1, {25'h1FFFFFF, gl[c]}, 0, 0); settle;
      `CHK("rxg", gl[c], rx_gain)
      `CHK("mix", gl[c] >= 7'd12, mix_reduce)
      `CHK("lna", gl[c] >= 7'd48, lna_reduce)
    end
    // Every filter code with effective gain, gain 48
    for (c = 0; c < 8; c++)
    begin
      apb(`RXC_IDX_BBCFG, 1, {20'hFFFFF, c[0], ~c[0], c[1], c[2:0], c[0] ? 5'd31 : 5'd9,
                               ~c[1]}, 0, 0);
      settle;
      g9 = 9'd48 - (c[0] ? 9'd31 : 9'd9) + ((c == 7) ? 9'd17 : 9'd8);
      `CHK("eff", g9, eff_gain)
      `CHK("fm", (c == 0) ? 2'd0 : (c == 2) ? 2'd1 : (c == 7) ? 2'd2 : 2'd3, filt_mode)
      `CHK("frsv", !(c == 0 || c == 2 || c == 7), filt_reserved)
      `CHK("vcm", c[0], vcm_high)
      `CHK("swp", {~c[0], c[1]}, {swap_q, swap_i})
      `CHK("osr", ~c[1], sdm_osr_4x)
    end
    // LNA threshold at 10: gain kept inside 12 to 102 dB, GSM filter, cal 31
    apb(`RXC_IDX_THRESH, 1, 32'h0000_0FAA, 0, 0);
    for (c = 0; c < 2; c++)
    begin
      apb(`RXC_IDX_GAIN, 1, c ? 32'd102 : 32'd12, 0, 0);
      settle;
      `CHK("lna10", c[0], lna_reduce)
      `CHK("mix10", c[0], mix_reduce)
      `CHK("eff10", c ? 9'd88 : 9'd510, eff_gain)
    end
    // Band select codes
    apb(`RXC_IDX_SYSCTL, 1, 32'h2, 0, 0); settle;
    `CHK("band", 3'b001, {high_band_input_two, high_band_input_one, low_band_input})
    apb(`RXC_IDX_SYSCTL, 1, 32'h6, 0, 0); settle;
    `CHK("band", 3'b100, {high_band_input_two, high_band_input_one, low_band_input})
    apb(`RXC_IDX_SYSCTL, 1, 32'h0, 0, 0); settle;
    `CHK("band", 3'b000, {high_band_input_two, high_band_input_one, low_band_input})
    // Soft reset: busy, writes ignored, defaults back
    apb(`RXC_IDX_SYSCTL, 1, 32'h1, 0, 0); settle;
    `CHK("srst", 1'b1, chip_reset_active)
    apb(`RXC_IDX_STATUS, 0, 0, 0, 32'h1);
    apb(`RXC_IDX_FREQ, 1, 32'h0000_1234, 0, 0);
    for (n = 0; n < 100 && chip_reset_active !== 1'b0; n++)
      @(posedge pclk);
    `CHK("srst_end", 1'b1, n < 20)
    settle;
    `CHK("srst_len", SRST_SIM, srst_cnt)
    chk_defaults;
    tally_and_finish;
  end : main
endmodule : tb

// *** verilog/rxc_defs.svh ***
`ifndef RXC_DEFS_SVH
`define RXC_DEFS_SVH

// ----------------------------------------------------------------
// Register indices and address width
// ----------------------------------------------------------------
`define RXC_IDX_FREQ        8'h0A
`define RXC_IDX_GAIN        8'h0B
`define RXC_IDX_THRESH      8'h0C
`define RXC_IDX_DUR         8'h0D
`define RXC_IDX_INTEG       8'h0E
`define RXC_IDX_BBCFG       8'h0F
`define RXC_IDX_SYSCTL      8'h10
`define RXC_IDX_STATUS      8'h11
`define RXC_ADDR_W          12

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RXC_RST_FREQ        16'h0000
`define RXC_RST_GAIN        16'h0000
`define RXC_RST_THRESH      16'h0FA6
`define RXC_RST_DUR         16'h103E
`define RXC_RST_INTEG       16'hEE53
`define RXC_RST_BBCFG       16'h0010
`define RXC_RST_BAND        2'h2

// ----------------------------------------------------------------
// Field masks and positions
// ----------------------------------------------------------------
`define RXC_MASK_GAIN       16'h007F
`define RXC_MASK_BBCFG      16'h0FFF
`define RXC_BB_VCM          11
`define RXC_BB_SWAPQ        10
`define RXC_BB_SWAPI        9
`define RXC_BB_FILT_LO      6
`define RXC_BB_CAL_LO       1
`define RXC_BB_OSR          0
`define RXC_SYS_RST         0
`define RXC_SYS_BAND_LO     1

// ----------------------------------------------------------------
// Filter codes, gain constants, timing
// ----------------------------------------------------------------
`define RXC_FILT_WC5        3'h0
`define RXC_FILT_WC7        3'h2
`define RXC_FILT_GSM        3'h7
`define RXC_GAIN_K_WCDMA    9'h008
`define RXC_GAIN_K_GSM      9'h011
`define RXC_STEP_DB         4
`define RXC_CLK_MHZ         200
`define RXC_SRST_US         50
`define RXC_SRST_CYC        (`RXC_SRST_US * `RXC_CLK_MHZ)

`endif

// *** verilog/rxc_pkg.sv ***
package rxc_pkg;
  typedef enum logic [1:0] {RXC_BAND_RSVD, RXC_BAND_LOW, RXC_BAND_HIGH1,
                            RXC_BAND_HIGH2} rxc_band_type;
  typedef enum logic [1:0] {RXC_FILT_WCDMA5, RXC_FILT_WCDMA7, RXC_FILT_GSM_M,
                            RXC_FILT_RESERVED} rxc_filt_type;
  typedef enum {RXC_RUN, RXC_SRST} rxc_state_type;
endpackage : rxc_pkg

// *** verilog/rxc_regs.sv ***
// How it works
// [RULE_01] 16-bit frequency word drives receive synthesizer linearly, 0 to 3276.75 MHz.
// [RULE_02] High-band inputs see twice channel frequency; low band sees half.
// [RULE_03] 7-bit gain field sets receive gain in 1 dB steps.
// [RULE_04] Effective gain is gain minus calibration plus 8 (WCDMA) or 17 (GSM).
// [RULE_05] Software keeps gain within 12 to 102 dB at default LNA threshold.
// [RULE_06] Per-state skip bits bypass offset control without RF gain step; default 0.
// [RULE_07] Per-state offset modulator enable bits; all enabled by default.
// [RULE_08] Mixer reduction threshold in 4 dB steps, default 10.
// [RULE_09] LNA reduction threshold in 4 dB steps, default 6.
// [RULE_10] Offset ADC range per state, default 1.
// [RULE_11] State 2, 1, 0 durations default 0, 3, 14.
// [RULE_12] Integrator constants states 3..0 default 14, 14, 5, 3.
// [RULE_13] Common-mode bit: 0 gives 1.2 V, 1 gives 1.4 V.
// [RULE_14] Separate bits swap Q and I differential output legs.
// [RULE_15] Filter code 000 WCDMA5, 010 WCDMA7, 111 GSM, others reserved.
// [RULE_16] Calibration spans 0 to 31 dB; write 8 when uncalibrated.
// [RULE_17] Oversampling bit: 1 gives 4x, 0 gives 2x default.
// [RULE_18] Band select: 01 low, 10 high one default, 11 high two.
// [RULE_19] Rising soft reset bit starts 50 us reset to defaults, self clearing.
// [RULE_20] Registers write-only, whole-word replace, unassigned bits ignored.
`timescale 1ns/1ps
`include "rxc_defs.svh"

module rxc_regs
  import rxc_pkg::*;
#(
  parameter int unsigned SRST_CYC = `RXC_SRST_CYC
)
(
  // APB
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`RXC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  // Synthesizer
  output logic [15:0]                 synth_freq_word,
  output logic [15:0]                 synth_lo_div_word,
  // Band select
  output logic                        low_band_input,
  output logic                        high_band_input_one,
  output logic                        high_band_input_two,
  // Gain
  output logic [6:0]                  rx_gain,
  output logic [4:0]                  gain_cal,
  output logic [8:0]                  eff_gain,
  output logic                        lna_reduce,
  output logic                        mix_reduce,
  // Offset loop
  output logic [3:0]                  skip_mask,
  output logic [3:0]                  sdm_enable,
  output logic [3:0]                  mix_thresh,
  output logic [3:0]                  lna_thresh,
  output logic [3:0]                  offset_adc_range,
  output logic [3:0]                  state2_duration,
  output logic [3:0]                  state1_duration,
  output logic [3:0]                  state0_duration,
  output logic [3:0]                  state3_integrator,
  output logic [3:0]                  state2_integrator,
  output logic [3:0]                  state1_integrator,
  output logic [3:0]                  state0_integrator,
  output logic                        sdm_osr_4x,
  // Baseband outputs and soft reset flag
  output logic                        vcm_high,
  output logic                        swap_q,
  output logic                        swap_i,
  output logic [1:0]                  filt_mode,
  output logic                        filt_reserved,
  output logic                        chip_reset_active
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [15:0] freq_reg,   freq_next;
  logic [15:0] gain_reg,   gain_next;
  logic [15:0] thr_reg,    thr_next;
  logic [15:0] dur_reg,    dur_next;
  logic [15:0] integ_reg,  integ_next;
  logic [15:0] bb_reg,     bb_next;
  logic [1:0]  band_reg,   band_next;
  logic        srbit_reg,  srbit_next;
  logic        ready_reg,  ready_next;
  logic        err_reg,    err_next;
  logic [31:0] rdata_reg,  rdata_next;
  logic        srst_busy;

  logic [7:0]  idx;
  logic        wr_acc;
  logic        mapped;
  logic        full_word;

  assign idx       = paddr[9:2];
  assign full_word = (pstrb[1:0] == 2'h3);
  assign mapped    = (paddr[1:0] == 2'h0) && (paddr[`RXC_ADDR_W-1:10] == '0)
                     && (idx >= `RXC_IDX_FREQ) && (idx <= `RXC_IDX_STATUS);
  // Access edge stores; pready rises on that same edge
  assign wr_acc    = psel && penable && pwrite && !ready_reg;

  rxc_soft_reset #(
    .PULSE_CYC (SRST_CYC)
  ) u_srst (
    .pclk    (pclk),
    .presetn (presetn),
    .rst_bit (srbit_reg),
    .busy    (srst_busy)
  );

  // ----------------------------------------------------------------
  // Write and bus response
  // ----------------------------------------------------------------
  always_comb
  begin
    freq_next  = freq_reg;
    gain_next  = gain_reg;
    thr_next   = thr_reg;
    dur_next   = dur_reg;
    integ_next = integ_reg;
    bb_next    = bb_reg;
    band_next  = band_reg;
    // [RULE_19] self clearing bit
    srbit_next = 1'b0;
    ready_next = psel && penable && !ready_reg;
    err_next   = 1'b0;
    rdata_next = 32'h0000_0000;
    if (psel && penable && !ready_reg)
    begin
      if (!mapped)
        err_next = 1'b1;
      else if (!pwrite)
      begin
        // Config words are write-only; only status reads back
        if (idx == `RXC_IDX_STATUS)
          rdata_next = {31'h0000_0000, srst_busy};
        else
          err_next = 1'b1;
      end
      else if (!full_word)
        err_next = 1'b1;
    end
    if (srst_busy)
    begin
      // [RULE_19] defaults restored during reset
      freq_next  = `RXC_RST_FREQ;
      gain_next  = `RXC_RST_GAIN;
      thr_next   = `RXC_RST_THRESH;
      dur_next   = `RXC_RST_DUR;
      integ_next = `RXC_RST_INTEG;
      bb_next    = `RXC_RST_BBCFG;
      band_next  = `RXC_RST_BAND;
    end
    else if (wr_acc && mapped && full_word)
    begin
      // [RULE_20] whole word replace
      case (idx)
        `RXC_IDX_FREQ:   freq_next  = pwdata[15:0];
        `RXC_IDX_GAIN:   gain_next  = pwdata[15:0] & `RXC_MASK_GAIN;
        `RXC_IDX_THRESH: thr_next   = pwdata[15:0];
        `RXC_IDX_DUR:    dur_next   = pwdata[15:0];
        `RXC_IDX_INTEG:  integ_next = pwdata[15:0];
        `RXC_IDX_BBCFG:  bb_next    = pwdata[15:0] & `RXC_MASK_BBCFG;
        `RXC_IDX_SYSCTL:
        begin
          srbit_next = pwdata[`RXC_SYS_RST];
          band_next  = pwdata[`RXC_SYS_BAND_LO +: 2];
        end
        default:
          freq_next = freq_reg;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      freq_reg  <= `RXC_RST_FREQ;
      gain_reg  <= `RXC_RST_GAIN;
      thr_reg   <= `RXC_RST_THRESH;
      dur_reg   <= `RXC_RST_DUR;
      integ_reg <= `RXC_RST_INTEG;
      bb_reg    <= `RXC_RST_BBCFG;
      band_reg  <= `RXC_RST_BAND;
      srbit_reg <= 1'b0;
      ready_reg <= 1'b0;
      err_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      freq_reg  <= freq_next;
      gain_reg  <= gain_next;
      thr_reg   <= thr_next;
      dur_reg   <= dur_next;
      integ_reg <= integ_next;
      bb_reg    <= bb_next;
      band_reg  <= band_next;
      srbit_reg <= srbit_next;
      ready_reg <= ready_next;
      err_reg   <= err_next;
      rdata_reg <= rdata_next;
    end
  end

  assign pready  = ready_reg;
  assign pslverr = err_reg;
  assign prdata  = rdata_reg;

  // ----------------------------------------------------------------
  // Derived control, registered
  // ----------------------------------------------------------------
  logic [15:0] lo_next,  lo_reg;
  logic [8:0]  eg_next,  eg_reg;
  logic [2:0]  bsel_next, bsel_reg;
  logic [1:0]  fm_next,  fm_reg;
  logic        frs_next, frs_reg;
  logic        lna_next, lna_reg;
  logic        mix_next, mix_reg;
  logic        busy_reg;
  logic [2:0]  fcode;
  logic [8:0]  gain_k;
  logic [8:0]  gain_db;

  assign fcode   = bb_reg[`RXC_BB_FILT_LO +: 3];
  assign gain_db = {2'h0, gain_reg[6:0]};

  always_comb
  begin
    // [RULE_02] low band runs at half the synth rate
    lo_next = {1'b0, freq_reg[15:1]};
    // [RULE_15] filter decode
    fm_next  = RXC_FILT_RESERVED;
    frs_next = 1'b1;
    case (fcode)
      `RXC_FILT_WC5:
      begin
        fm_next  = RXC_FILT_WCDMA5;
        frs_next = 1'b0;
      end
      `RXC_FILT_WC7:
      begin
        fm_next  = RXC_FILT_WCDMA7;
        frs_next = 1'b0;
      end
      `RXC_FILT_GSM:
      begin
        fm_next  = RXC_FILT_GSM_M;
        frs_next = 1'b0;
      end
      default:
        frs_next = 1'b1;
    endcase
    // [RULE_04] gain offset by filter family
    gain_k  = (fcode == `RXC_FILT_GSM) ? `RXC_GAIN_K_GSM : `RXC_GAIN_K_WCDMA;
    eg_next = gain_db - {4'h0, bb_reg[`RXC_BB_CAL_LO +: 5]} + gain_k;
    // [RULE_08] mixer reduction at threshold
    mix_next = gain_db >= 9'(thr_reg[7:4] * `RXC_STEP_DB);
    // [RULE_09] LNA reduction at threshold
    lna_next = gain_db >= 9'(thr_reg[3:0] * `RXC_STEP_DB);
    // [RULE_18] band path decode
    case (rxc_band_type'(band_reg))
      RXC_BAND_LOW:   bsel_next = 3'h1;
      RXC_BAND_HIGH1: bsel_next = 3'h2;
      RXC_BAND_HIGH2: bsel_next = 3'h4;
      default:        bsel_next = 3'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lo_reg   <= 16'h0000;
      eg_reg   <= 9'h000;
      bsel_reg <= 3'h2;
      fm_reg   <= RXC_FILT_WCDMA5;
      frs_reg  <= 1'b0;
      lna_reg  <= 1'b0;
      mix_reg  <= 1'b0;
      busy_reg <= 1'b0;
    end
    else
    begin
      lo_reg   <= lo_next;
      eg_reg   <= eg_next;
      bsel_reg <= bsel_next;
      fm_reg   <= fm_next;
      frs_reg  <= frs_next;
      lna_reg  <= lna_next;
      mix_reg  <= mix_next;
      busy_reg <= srst_busy;
    end
  end

  // ----------------------------------------------------------------
  // Output fields
  // ----------------------------------------------------------------
  // [RULE_01] linear frequency word
  assign synth_freq_word     = freq_reg;
  assign synth_lo_div_word   = lo_reg;
  assign low_band_input      = bsel_reg[0];
  assign high_band_input_one = bsel_reg[1];
  assign high_band_input_two = bsel_reg[2];
  // [RULE_03] raw gain code
  assign rx_gain             = gain_reg[6:0];
  // [RULE_16] calibration passed through
  assign gain_cal            = bb_reg[`RXC_BB_CAL_LO +: 5];
  assign eff_gain            = eg_reg;
  assign lna_reduce          = lna_reg;
  assign mix_reduce          = mix_reg;
  // [RULE_06] skip mask
  assign skip_mask           = thr_reg[15:12];
  // [RULE_07] modulator enables
  assign sdm_enable          = thr_reg[11:8];
  assign mix_thresh          = thr_reg[7:4];
  assign lna_thresh          = thr_reg[3:0];
  // [RULE_10] ADC range
  assign offset_adc_range    = dur_reg[15:12];
  // [RULE_11] state durations
  assign state2_duration     = dur_reg[11:8];
  assign state1_duration     = dur_reg[7:4];
  assign state0_duration     = dur_reg[3:0];
  // [RULE_12] integrator constants
  assign state3_integrator   = integ_reg[15:12];
  assign state2_integrator   = integ_reg[11:8];
  assign state1_integrator   = integ_reg[7:4];
  assign state0_integrator   = integ_reg[3:0];
  // [RULE_17] oversampling select
  assign sdm_osr_4x          = bb_reg[`RXC_BB_OSR];
  // [RULE_13] common mode select
  assign vcm_high            = bb_reg[`RXC_BB_VCM];
  // [RULE_14] leg swaps
  assign swap_q              = bb_reg[`RXC_BB_SWAPQ];
  assign swap_i              = bb_reg[`RXC_BB_SWAPI];
  assign filt_mode           = fm_reg;
  assign filt_reserved       = frs_reg;
  assign chip_reset_active   = busy_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence wr_word_s(logic [7:0] i);
    psel && penable && pwrite && !pready && mapped && full_word && idx == i && !srst_busy;
  endsequence

  freq_write_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_01]
    wr_word_s(`RXC_IDX_FREQ) |=> synth_freq_word == $past(pwdata[15:0]))
    else $error("frequency word not stored");
  lo_half_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_02]
    wr_word_s(`RXC_IDX_FREQ) |=> ##1 synth_lo_div_word == (synth_freq_word >> 1))
    else $error("low band word not half");
  gain_mask_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_03]
    wr_word_s(`RXC_IDX_GAIN) |=> rx_gain == $past(pwdata[6:0]))
    else $error("gain field wrong");
  eff_gain_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_04]
    $stable(bb_reg) && $stable(gain_reg) |-> eff_gain == 9'({2'h0, rx_gain}
      - {4'h0, gain_cal} + ((bb_reg[8:6] == 3'h7) ? 9'h011 : 9'h008)))
    else $error("effective gain wrong");
  lna_step_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_09]
    $stable(thr_reg) && $stable(gain_reg) |-> lna_reduce == ({2'h0, rx_gain} >= 9'(lna_thresh * 4)))
    else $error("LNA step decode wrong");
  filt_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_15]
    $stable(bb_reg) |-> filt_reserved == !(fcode inside {3'h0, 3'h2, 3'h7}))
    else $error("filter reserved flag wrong");
  srst_dflt_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_19]
    srst_busy |=> thr_reg == `RXC_RST_THRESH && integ_reg == `RXC_RST_INTEG)
    else $error("defaults not restored");
  srbit_clr_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_19]
    srbit_reg |=> !srbit_reg)
    else $error("soft reset bit sticks");
  read_err_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_20]
    psel && penable && !pwrite && !pready && idx != `RXC_IDX_STATUS |=> pslverr)
    else $error("write-only read not refused");

endmodule : rxc_regs

// *** verilog/rxc_soft_reset.sv ***
`timescale 1ns/1ps
`include "rxc_defs.svh"

module rxc_soft_reset
  import rxc_pkg::*;
#(
  parameter int unsigned PULSE_CYC = `RXC_SRST_CYC
)
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control
  input  wire logic rst_bit,
  output logic      busy
);

  rxc_state_type state_reg;
  rxc_state_type state_next;
  logic [15:0]   cnt_reg;
  logic [15:0]   cnt_next;
  logic          bit_reg;
  logic          bit_next;

  // [RULE_19] rising edge starts pulse
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    bit_next   = rst_bit;
    case (state_reg)
      RXC_RUN:
      begin
        if (rst_bit && !bit_reg)
        begin
          state_next = RXC_SRST;
          cnt_next   = 16'(PULSE_CYC - 1);
        end
      end
      RXC_SRST:
      begin
        if (cnt_reg == 16'h0000)
          state_next = RXC_RUN;
        else
          cnt_next = cnt_reg - 16'h0001;
      end
      default:
        state_next = RXC_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= RXC_RUN;
      cnt_reg   <= 16'h0000;
      bit_reg   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      bit_reg   <= bit_next;
    end
  end

  assign busy = (state_reg == RXC_SRST);

  srst_len_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_19]
    $rose(busy) |-> busy [*8])
    else $error("soft reset pulse too short");

endmodule : rxc_soft_reset
